/* hdl/pwm_center_six.sv */
// Six-channel center-aligned PWM generator with AXI4-Lite register slave
//
// Overview of operation
// - Six independent channels, each center-aligned with an 8-bit duty value.
// - Base frequency is counting clock divided by 512: count up then down.
// - Duty writes land in a shadow, never changing the active compare mid-period.
// - Duty ranges from never active up to 255/256; full duty unreachable.
// - Clock scaling register: run enable bit 7, scaling bits 6-0, reset zero.
// - Zero interrupt enable at bit 5 raises interrupt when counter reaches zero while IRQ mask bit 1 is set.
// - Center interrupt enable at bit 4 raises interrupt at counter turnaround while IRQ mask bit 0 is set.
// - Zero event sets flag bit 1; stays set until software clears it.
// - Center event sets flag bit 0; stays set until software clears it.
// - Duty registers reset to zero; zero duty holds output low all period.
// - New duty is loaded into the comparator when a period completes, or at once while stopped.
// - Per-channel polarity bit; one inverts that channel's output while running.
//
// The implementer's own choice: the AXI4-Lite register port.
module pwm_center_six (
	input  wire logic        clk,     // Core clock, 40 MHz
	input  wire logic        nrst,    // Async reset, active low
	input  wire logic [17:0] awaddr,  // Write address
	input  wire logic [2:0]  awprot,  // Write protection, unused
	input  wire logic        awvalid, // Write address valid
	output logic             awready, // Write address ready
	input  wire logic [31:0] wdata,   // Write data
	input  wire logic [3:0]  wstrb,   // Write byte strobes
	input  wire logic        wvalid,  // Write data valid
	output logic             wready,  // Write data ready
	output logic [1:0]       bresp,   // Write response
	output logic             bvalid,  // Write response valid
	input  wire logic        bready,  // Write response ready
	input  wire logic [17:0] araddr,  // Read address
	input  wire logic [2:0]  arprot,  // Read protection, unused
	input  wire logic        arvalid, // Read address valid
	output logic             arready, // Read address ready
	output logic [31:0]      rdata,   // Read data
	output logic [1:0]       rresp,   // Read response
	output logic             rvalid,  // Read data valid
	input  wire logic        rready,  // Read data ready
	output logic [5:0]       pwmOut,  // Channel outputs toward GPIO
	output logic             irq      // Level interrupt
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                awHeld;
		logic [17:0]         awAddr;
		logic                wHeld;
		logic [31:0]         wData;
		logic                wLow;
		logic                bValid;
		logic [1:0]          bResp;
		logic                arPend;
		logic                arWait;
		logic [17:0]         arAddr;
		logic                rValid;
		logic [31:0]         rData;
		logic [1:0]          rResp;
		logic [7:0]          clockScaling;
		logic [1:0]          irqEnable;
		logic [1:0]          irqFlags;
		logic [1:0]          irqStatus;
		logic [1:0]          irqMask;
		logic [5:0]          polarity;
		logic [6:0]          prescale;
		logic [7:0]          count;
		pwm_pkg::count_dir_e dir;
		logic [5:0][7:0]     active;
		logic [5:0]          outs;
	} state_s;

	state_s s_q;
	state_s s_d;

	pwm_pkg::duty_write_s dutyWr;
	pwm_pkg::duty_read_s  dutyRd;
	logic [47:0]          shadow;
	logic [2:0]           rdChan;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic isDuty(input logic [17:0] a);
		return a >= pwm_pkg::ADDR_DUTY0 &&
			a < pwm_pkg::ADDR_DUTY0 + 18'(pwm_pkg::NUM_CH * 4) && a[1:0] == 2'b00;
	endfunction

	function automatic logic [2:0] dutyChan(input logic [17:0] a);
		logic [17:0] off;
		off = a - pwm_pkg::ADDR_DUTY0;
		return off[4:2];
	endfunction

	function automatic logic isMapped(input logic [17:0] a);
		return a == pwm_pkg::ADDR_CLOCK_SCALING || a == pwm_pkg::ADDR_INTERRUPT_CONTROL ||
			a == pwm_pkg::ADDR_POLARITY || a == pwm_pkg::ADDR_IRQ_STATUS ||
			a == pwm_pkg::ADDR_IRQ_MASK || isDuty(a);
	endfunction

	function automatic logic [1:0] stickyNext(input logic [1:0] cur, input logic [1:0] clr,
		input logic [1:0] set);
		// Set wins over a clear in the same cycle
		return (cur & ~clr) | set;
	endfunction

	assign rdChan = dutyChan(s_q.arAddr);

	duty_buffer shadowStore (
		.clk    (clk),
		.nrst   (nrst),
		.wr     (dutyWr),
		.rdChan (rdChan),
		.rd     (dutyRd),
		.shadow (shadow)
	);

	// ****************************************
	// Next state
	// ****************************************
	logic       doWrite;
	logic       tick;
	logic       periodEnd;
	logic       zeroEvt;
	logic       centerEvt;
	logic [1:0] flagClr;
	logic [1:0] statClr;
	logic [1:0] newEvt;

	always_comb begin
		s_d = s_q;
		dutyWr = '{valid: 1'b0, data: pwm_pkg::RESET_BYTE, chan: 3'd0};
		flagClr = 2'b00;
		statClr = 2'b00;

		// ****************************************
		// Register write
		// ****************************************
		// Address and data taken independently
		if (awvalid && !s_q.awHeld) begin
			s_d.awHeld = 1'b1;
			s_d.awAddr = awaddr;
		end
		if (wvalid && !s_q.wHeld) begin
			s_d.wHeld = 1'b1;
			s_d.wData = wdata;
			s_d.wLow = wstrb[0];
		end
		doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
		if (doWrite) begin
			s_d.awHeld = 1'b0;
			s_d.wHeld = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp = isMapped(s_q.awAddr) ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
			if (s_q.wLow) begin
				unique case (1'b1)
					s_q.awAddr == pwm_pkg::ADDR_CLOCK_SCALING: begin
						s_d.clockScaling = s_q.wData[7:0];
					end
					s_q.awAddr == pwm_pkg::ADDR_INTERRUPT_CONTROL: begin
						s_d.irqEnable = s_q.wData[pwm_pkg::ZERO_IRQ_EN_BIT -: 2];
						flagClr = ~s_q.wData[1:0];
					end
					s_q.awAddr == pwm_pkg::ADDR_POLARITY: begin
						s_d.polarity = s_q.wData[5:0];
					end
					s_q.awAddr == pwm_pkg::ADDR_IRQ_STATUS: begin
						statClr = s_q.wData[1:0];
					end
					s_q.awAddr == pwm_pkg::ADDR_IRQ_MASK: begin
						s_d.irqMask = s_q.wData[1:0];
					end
					isDuty(s_q.awAddr): begin
						dutyWr = '{valid: 1'b1, data: s_q.wData[7:0],
							chan: dutyChan(s_q.awAddr)};
					end
					default: begin
					end
				endcase
			end
		end
		if (s_q.bValid && bready) begin
			s_d.bValid = 1'b0;
		end

		// ****************************************
		// Register read
		// ****************************************
		// Capture, then wait out the buffer's registered read port
		if (arvalid && !s_q.arPend && !s_q.arWait && !s_q.rValid) begin
			s_d.arPend = 1'b1;
			s_d.arAddr = araddr;
		end
		if (s_q.arPend) begin
			s_d.arPend = 1'b0;
			s_d.arWait = 1'b1;
		end
		if (s_q.arWait) begin
			s_d.arWait = 1'b0;
			s_d.rValid = 1'b1;
			s_d.rResp = isMapped(s_q.arAddr) ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
			s_d.rData = '0;
			unique case (1'b1)
				s_q.arAddr == pwm_pkg::ADDR_CLOCK_SCALING: s_d.rData[7:0] = s_q.clockScaling;
				s_q.arAddr == pwm_pkg::ADDR_INTERRUPT_CONTROL: begin
					s_d.rData[pwm_pkg::ZERO_IRQ_EN_BIT -: 2] = s_q.irqEnable;
					s_d.rData[1:0] = s_q.irqFlags;
				end
				s_q.arAddr == pwm_pkg::ADDR_POLARITY: s_d.rData[5:0] = s_q.polarity;
				s_q.arAddr == pwm_pkg::ADDR_IRQ_STATUS: s_d.rData[1:0] = s_q.irqStatus;
				s_q.arAddr == pwm_pkg::ADDR_IRQ_MASK: s_d.rData[1:0] = s_q.irqMask;
				isDuty(s_q.arAddr): s_d.rData[7:0] = dutyRd.rdata;
				default: begin
				end
			endcase
		end
		if (s_q.rValid && rready) begin
			s_d.rValid = 1'b0;
		end

		// ****************************************
		// Counting clock and up/down counter
		// ****************************************
		tick = 1'b0;
		if (!s_q.clockScaling[pwm_pkg::RUN_ENABLE_BIT]) begin
			s_d.prescale = pwm_pkg::PRESCALE_ZERO;
			s_d.count = pwm_pkg::COUNT_ZERO;
			s_d.dir = pwm_pkg::DIR_UP;
		end else if (s_q.prescale >= s_q.clockScaling[6:0]) begin
			s_d.prescale = pwm_pkg::PRESCALE_ZERO;
			tick = 1'b1;
		end else begin
			s_d.prescale = s_q.prescale + 7'd1;
		end
		periodEnd = 1'b0;
		zeroEvt = 1'b0;
		centerEvt = 1'b0;
		if (tick) begin
			unique case (s_q.dir)
				pwm_pkg::DIR_UP: begin
					if (s_q.count == pwm_pkg::COUNT_MAX) begin
						s_d.dir = pwm_pkg::DIR_DOWN;
						centerEvt = 1'b1;
					end else begin
						s_d.count = s_q.count + 8'd1;
					end
				end
				pwm_pkg::DIR_DOWN: begin
					if (s_q.count == pwm_pkg::COUNT_ZERO) begin
						s_d.dir = pwm_pkg::DIR_UP;
						zeroEvt = 1'b1;
						periodEnd = 1'b1;
					end else begin
						s_d.count = s_q.count - 8'd1;
					end
				end
			endcase
		end
		// While stopped the comparators follow the shadow directly
		if (periodEnd || !s_q.clockScaling[pwm_pkg::RUN_ENABLE_BIT]) begin
			s_d.active = shadow;
		end

		// ****************************************
		// Channel outputs
		// ****************************************
		for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
			s_d.outs[i] = s_d.clockScaling[pwm_pkg::RUN_ENABLE_BIT] &&
				((s_d.count < s_d.active[i]) ^ s_q.polarity[i]);
		end

		// ****************************************
		// Flags and interrupt status, set wins
		// ****************************************
		newEvt = {zeroEvt, centerEvt};
		s_d.irqFlags = stickyNext(s_q.irqFlags, flagClr, newEvt);
		s_d.irqStatus = stickyNext(s_q.irqStatus, statClr, newEvt & s_q.irqEnable);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = !s_q.awHeld;
	assign wready = !s_q.wHeld;
	assign bvalid = s_q.bValid;
	assign bresp = s_q.bResp;
	assign arready = !s_q.arPend && !s_q.arWait && !s_q.rValid;
	assign rvalid = s_q.rValid;
	assign rdata = s_q.rData;
	assign rresp = s_q.rResp;
	assign pwmOut = s_q.outs;
	// Level interrupt from unmasked status bits
	assign irq = |(s_q.irqStatus & s_q.irqMask);

endmodule

/* hdl/pwm_pkg.sv */
// Package with register map, field positions and types of the six-channel PWM
package pwm_pkg;

	// ****************************************
	// Register indices and byte addresses
	// ****************************************
	localparam logic [15:0] IDX_CLOCK_SCALING     = 16'ha080;
	localparam logic [15:0] IDX_INTERRUPT_CONTROL = 16'ha081;
	localparam logic [15:0] IDX_POLARITY          = 16'ha082;
	localparam logic [15:0] IDX_DUTY0             = 16'ha088;
	localparam int          NUM_CH                = 6;
	localparam int          ADDR_W                = 18;
	localparam logic [17:0] ADDR_CLOCK_SCALING     = {IDX_CLOCK_SCALING, 2'b00};
	localparam logic [17:0] ADDR_INTERRUPT_CONTROL = {IDX_INTERRUPT_CONTROL, 2'b00};
	localparam logic [17:0] ADDR_POLARITY          = {IDX_POLARITY, 2'b00};
	localparam logic [17:0] ADDR_DUTY0             = {IDX_DUTY0, 2'b00};
	localparam logic [17:0] ADDR_IRQ_STATUS        = 18'h2_8260;
	localparam logic [17:0] ADDR_IRQ_MASK          = 18'h2_8264;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         RUN_ENABLE_BIT     = 7;
	localparam int         ZERO_IRQ_EN_BIT    = 5;
	localparam int         CENTER_IRQ_EN_BIT  = 4;
	localparam int         ZERO_IRQ_FLAG_BIT  = 1;
	localparam int         CENTER_IRQ_FLAG_BIT = 0;
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam logic [7:0] COUNT_MAX          = 8'hff;
	localparam logic [7:0] COUNT_ZERO         = 8'h00;
	localparam logic [6:0] PRESCALE_ZERO      = 7'h00;
	localparam logic [1:0] RESP_OKAY          = 2'b00;
	localparam logic [1:0] RESP_SLVERR        = 2'b10;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [0:0] {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} count_dir_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic [2:0] chan;
	} duty_write_s;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
	} duty_read_s;

endpackage

/* hdl/duty_buffer.sv */
// Shadow store for the six channel duty values with registered read port
module duty_buffer (
	input  wire logic                 clk,    // Core clock
	input  wire logic                 nrst,   // Async reset, active low
	input  wire pwm_pkg::duty_write_s wr,     // Software write into the shadow
	input  wire logic [2:0]           rdChan, // Channel to read back
	output pwm_pkg::duty_read_s       rd,     // Registered read data
	output logic [47:0]               shadow  // All shadow values, channel 0 lowest
);

	typedef struct packed {
		logic [5:0][7:0] mem;
		logic            rvalid;
		logic [7:0]      rdata;
	} state_s;

	state_s s_q;
	state_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b1;
		s_d.rdata = (rdChan < 3'(pwm_pkg::NUM_CH)) ? s_q.mem[rdChan] : pwm_pkg::RESET_BYTE;
		if (wr.valid && wr.chan < 3'(pwm_pkg::NUM_CH)) begin
			s_d.mem[wr.chan] = wr.data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd = '{rvalid: s_q.rvalid, rdata: s_q.rdata};
	assign shadow = s_q.mem;

endmodule

/* verif/pwm_center_six_properties.sv */
// Port-level assertions for the six-channel PWM block
module pwm_center_six_properties (
	input wire logic        clk,     // Core clock
	input wire logic        nrst,    // Async reset, active low
	input wire logic        awvalid, // Write address valid
	input wire logic        awready, // Write address ready
	input wire logic        wvalid,  // Write data valid
	input wire logic        wready,  // Write data ready
	input wire logic [1:0]  bresp,   // Write response
	input wire logic        bvalid,  // Write response valid
	input wire logic        bready,  // Write response ready
	input wire logic        arvalid, // Read address valid
	input wire logic        arready, // Read address ready
	input wire logic [31:0] rdata,   // Read data
	input wire logic [1:0]  rresp,   // Read response
	input wire logic        rvalid,  // Read data valid
	input wire logic        rready   // Read data ready
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence wrTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence wrAnswer;
		!bvalid ##1 bvalid;
	endsequence
	a_write_answer: assert property (wrTaken |=> wrAnswer)
		else $error("write response not two cycles after transfer");
	a_read_answer: assert property (arvalid && arready |-> ##[2:3] rvalid)
		else $error("read data late");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_read_busy: assert property (rvalid |-> !arready)
		else $error("read address taken while data pending");
	a_slverr_zero: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0000_0000)
		else $error("error read returned data");
	a_bresp_legal: assert property (bvalid |-> bresp == 2'b00 || bresp == 2'b10)
		else $error("illegal write response");
endmodule

bind pwm_center_six pwm_center_six_properties u_props (
	.clk(clk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);

/* verif/pwm_load.sv */
// Load model on the six PWM pins, counting high cycles per channel
module pwm_load (
	input  wire logic        clk,     // Core clock
	input  wire logic        clear,   // Restart the counts
	input  wire logic [5:0]  pwmOut,  // Channel pins
	output logic      [59:0] highCnt  // Ten-bit high count per channel
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge clk) begin
		for (int i = 0; i < 6; i++) begin
			if (clear)
				highCnt[i*10 +: 10] <= 10'h000;
			else
				highCnt[i*10 +: 10] <= highCnt[i*10 +: 10] + {9'h000, pwmOut[i]};
		end
	end
endmodule

/* verif/testbench.sv */
// Self-checking testbench for the six-channel center-aligned PWM block
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
	$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [17:0] CS  = pwm_pkg::ADDR_CLOCK_SCALING;
	localparam logic [17:0] IC  = pwm_pkg::ADDR_INTERRUPT_CONTROL;
	localparam logic [17:0] ST  = pwm_pkg::ADDR_IRQ_STATUS;
	localparam logic [17:0] MSK = pwm_pkg::ADDR_IRQ_MASK;
	localparam logic [1:0]  OK  = pwm_pkg::RESP_OKAY;
	logic        clk = 1'b0, nrst = 1'b0, clear = 1'b0, irq;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        awready, wready, arready, bvalid, rvalid;
	logic [17:0] awaddr = 18'h0_0000, araddr = 18'h0_0000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0]  bresp, rresp;
	logic [5:0]  pwmOut;
	logic [59:0] highCnt;
	logic [7:0]  duty [6] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'hfe, 8'hff};
	int          numErrors = 0, nCompared = 0;

	always #12.5 clk = ~clk;

	pwm_center_six u_dut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(1'b1), .pwmOut(pwmOut), .irq(irq));
	pwm_load u_load (.clk(clk), .clear(clear), .pwmOut(pwmOut), .highCnt(highCnt));

	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] rs;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge clk);
			aw = awready && awvalid;
			w = wready && wvalid;
			b = bvalid;
			rs = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		`CHK(rs, er)
	endtask

	task automatic rd(input logic [17:0] a, input logic [7:0] ed, input logic [1:0] er);
		logic ar, r;
		logic [31:0] d;
		logic [1:0] rs;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			ar = arready && arvalid;
			r = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
		end while (!r);
		`CHK(d, {24'h00_0000, ed})
		`CHK(rs, er)
	endtask

	task automatic chkIrq(input logic e);
		@(negedge clk);
		`CHK(irq, e)
		@(posedge clk);
	endtask

	function automatic logic [59:0] expVec(int k, logic [5:0] p, logic run);
		logic [59:0] e;
		int v;
		for (int i = 0; i < 6; i++) begin
			v = 2 * k * duty[i];
			if (p[i]) v = 512 * k - v;
			e[i*10 +: 10] = run ? 10'(v) : 10'h000;
		end
		return e;
	endfunction

	// Counts high cycles over a window of n clocks
	task automatic meas(input int n, input logic [59:0] e);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (n) @(posedge clk);
		@(negedge clk);
		`CHK(highCnt, e)
		@(posedge clk);
	endtask

	task automatic t_reset();
		rd(CS, 8'h00, OK);
		rd(IC, 8'h00, OK);
		for (int i = 0; i < 6; i++) rd(pwm_pkg::ADDR_DUTY0 + 18'(4 * i), 8'h00, OK);
		rd(18'h2_8300, 8'h00, 2'b10);
		wr(18'h2_8300, 8'h5a, 2'b10);
		wr(CS, 8'h7f, OK);
		rd(CS, 8'h7f, OK);
		$display("reset and map test done");
	endtask

	task automatic t_duty();
		for (int i = 0; i < 6; i++) wr(pwm_pkg::ADDR_DUTY0 + 18'(4 * i), duty[i], OK);
		for (int i = 0; i < 6; i++) rd(pwm_pkg::ADDR_DUTY0 + 18'(4 * i), duty[i], OK);
		wr(CS, 8'h80, OK);
		repeat (1100) @(posedge clk);
		meas(512, expVec(1, 6'h00, 1'b1));
		wr(CS, 8'h81, OK);
		repeat (2100) @(posedge clk);
		meas(1024, expVec(2, 6'h00, 1'b1));
		$display("duty test done");
	endtask

	task automatic t_pol();
		wr(CS, 8'h80, OK);
		wr(pwm_pkg::ADDR_POLARITY, 8'h22, OK);
		rd(pwm_pkg::ADDR_POLARITY, 8'h22, OK);
		repeat (1100) @(posedge clk);
		meas(512, expVec(1, 6'h22, 1'b1));
		wr(CS, 8'h00, OK);
		meas(512, expVec(1, 6'h22, 1'b0));
		$display("polarity test done");
	endtask

	task automatic t_irq();
		wr(CS, 8'h80, OK);
		repeat (1100) @(posedge clk);
		wr(CS, 8'h00, OK);
		rd(ST, 8'h00, OK);
		rd(IC, 8'h03, OK);
		wr(IC, 8'h30, OK);
		rd(IC, 8'h30, OK);
		wr(MSK, 8'h03, OK);
		wr(CS, 8'h80, OK);
		for (int i = 0; i < 1100 && irq !== 1'b1; i++) @(posedge clk);
		chkIrq(1'b1);
		repeat (600) @(posedge clk);
		wr(CS, 8'h00, OK);
		rd(ST, 8'h03, OK);
		rd(IC, 8'h33, OK);
		wr(ST, 8'h01, OK);
		rd(ST, 8'h02, OK);
		chkIrq(1'b1);
		wr(MSK, 8'h01, OK);
		chkIrq(1'b0);
		wr(ST, 8'h02, OK);
		rd(ST, 8'h00, OK);
		$display("interrupt test done");
	endtask

	task automatic stopTest();
		$display("compared %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#1_000_000;
		numErrors++;
		stopTest();
	end

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_duty();
		t_pol();
		t_irq();
		stopTest();
	end
endmodule
